/* File: include/srt_cfg.svh */
// Address map, field positions, reset values and timing counts of the reload timer.
`ifndef SRT_CFG_SVH
`define SRT_CFG_SVH

`define SRT_ADDR_W        8
`define SRT_OFS_CTRL      8'h00
`define SRT_OFS_CLKCTL    8'h04
`define SRT_OFS_IE        8'h08
`define SRT_OFS_CNT_LO    8'h0c
`define SRT_OFS_CNT_HI    8'h10
`define SRT_OFS_RLD_LO    8'h14
`define SRT_OFS_RLD_HI    8'h18
`define SRT_OFS_IRQ_ST    8'h1c
`define SRT_OFS_IRQ_MASK  8'h20

`define SRT_BIT_LO_SEL    4
`define SRT_BIT_HI_SEL    5
`define SRT_BIT_TMR_IE    5
`define SRT_ST_HI         0
`define SRT_ST_LO         1

`define SRT_CTRL_RST      8'h00
`define SRT_CTRL_WMASK    8'hfd
`define SRT_CLKCTL_RST    8'h00
`define SRT_IE_RST        8'h00
`define SRT_MASK_RST      2'h3

`define SRT_RESP_OKAY     2'h0
`define SRT_RESP_SLVERR   2'h2

`define SRT_SYS_DIV       4'hc
`define SRT_EXT_DIV       4'h8

`endif

/* File: include/srt_pkg.sv */
// Types shared by the reload timer modules.
package srt_pkg;

   typedef logic [7:0] srt_byte_t;

   typedef struct packed {
      logic hiFlag;
      logic loFlag;
      logic loIrqEn;
      logic capEn;
      logic split;
      logic run;
      logic rsvd;
      logic extSel;
   } srt_ctrl_s;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } srt_wr_s;

endpackage

/* File: design/srt_tick_gen.sv */
// Count-rate enables: system clock by twelve, and synchronised external oscillator by eight.
`timescale 1ns/1ns
`include "srt_cfg.svh"
module srt_tick_gen
(
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic extOsc,
   output logic      tickDiv12,
   output logic      tickExt8,
   output logic      captureEvt
);
   logic [3:0] preCnt_reg;
   logic [2:0] extCnt_reg;
   logic       sync1_reg;
   logic       sync2_reg;
   logic       sync3_reg;
   logic       oscRise;

   // ****************************************
   // System clock prescaler
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         preCnt_reg <= 4'h0;
         tickDiv12  <= 1'b0;
      end
      else
      begin
         tickDiv12  <= (preCnt_reg == `SRT_SYS_DIV - 4'h1);
         preCnt_reg <= (preCnt_reg == `SRT_SYS_DIV - 4'h1) ? 4'h0 : preCnt_reg + 4'h1;
      end
   end

   // ****************************************
   // External oscillator synchroniser and divider
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= extOsc;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign oscRise = sync2_reg & ~sync3_reg;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         extCnt_reg <= 3'h0;
         tickExt8   <= 1'b0;
         captureEvt <= 1'b0;
      end
      else
      begin
         if (oscRise)
         begin
            extCnt_reg <= extCnt_reg + 3'h1;
         end
         tickExt8   <= oscRise & (extCnt_reg == 3'h3);
         captureEvt <= oscRise & (extCnt_reg == 3'(`SRT_EXT_DIV - 4'h1));
      end
   end
endmodule

/* File: design/srt_axil_slave.sv */
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ns
`include "srt_cfg.svh"
module srt_axil_slave
(
   input  wire logic           core_clk,
   input  wire logic           nrst,
   input  wire logic           awvalid,
   output logic                awready,
   input  wire logic [7:0]     awaddr,
   input  wire logic           wvalid,
   output logic                wready,
   input  wire logic [31:0]    wdata,
   input  wire logic [3:0]     wstrb,
   output logic                bvalid,
   input  wire logic           bready,
   output logic [1:0]          bresp,
   input  wire logic           arvalid,
   output logic                arready,
   input  wire logic [7:0]     araddr,
   output logic                rvalid,
   input  wire logic           rready,
   output logic [31:0]         rdata,
   output logic [1:0]          rresp,
   output logic                wrEn,
   output srt_pkg::srt_wr_s    wrReq,
   input  wire logic           wrOk,
   output logic                rdEn,
   input  wire logic [31:0]    rdData,
   input  wire logic           rdOk
);
   import srt_pkg::*;
   logic awHeld_reg;
   logic wHeld_reg;

   assign wrEn = awHeld_reg & wHeld_reg & ~bvalid;
   assign rdEn = arvalid & arready;

   // ****************************************
   // Write channels
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         awready    <= 1'b1;
         wready     <= 1'b1;
         bvalid     <= 1'b0;
         bresp      <= `SRT_RESP_OKAY;
         wrReq      <= '0;
      end
      else
      begin
         if (awvalid & awready)
         begin
            awHeld_reg  <= 1'b1;
            awready     <= 1'b0;
            wrReq.addr  <= awaddr;
         end
         if (wvalid & wready)
         begin
            wHeld_reg   <= 1'b1;
            wready      <= 1'b0;
            wrReq.data  <= wdata;
            wrReq.strb  <= wstrb;
         end
         if (wrEn)
         begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bvalid     <= 1'b1;
            bresp      <= wrOk ? `SRT_RESP_OKAY : `SRT_RESP_SLVERR;
         end
         if (bvalid & bready)
         begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // ****************************************
   // Read channels
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `SRT_RESP_OKAY;
      end
      else
      begin
         if (rdEn)
         begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdData;
            rresp   <= rdOk ? `SRT_RESP_OKAY : `SRT_RESP_SLVERR;
         end
         if (rvalid & rready)
         begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule

/* File: design/srt_timer.sv */
// Sixteen-bit reload timer with split, capture and interrupt logic behind an AXI4-Lite port.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "srt_cfg.svh"
module srt_timer
   import srt_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        extOsc,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             irq
);
   import srt_pkg::*;

   srt_ctrl_s  ctrl_reg;
   srt_byte_t  clkCtl_reg;
   srt_byte_t  intEn_reg;
   srt_byte_t  cntLo_reg;
   srt_byte_t  cntHi_reg;
   srt_byte_t  rldLo_reg;
   srt_byte_t  rldHi_reg;
   logic [1:0] irqSt_reg;
   logic [1:0] irqMask_reg;

   srt_byte_t  cntLo_next;
   srt_byte_t  cntHi_next;
   logic       irq_next;

   logic       tickDiv12;
   logic       tickExt8;
   logic       captureEvt;

   logic       wrEn;
   srt_wr_s    wrReq;
   logic       wrOk;
   logic       rdEn;
   logic [31:0] rdData;
   logic       rdOk;

   logic       wrSel;
   logic       ctrlWr;
   logic       clkWr;
   logic       ieWr;
   logic       cntLoWr;
   logic       cntHiWr;
   logic       rldLoWr;
   logic       rldHiWr;
   logic       maskWr;
   logic       stRd;

   logic       extLo;
   logic       tickLo;
   logic       tickHi;
   logic       step16;
   logic       wrap16;
   logic       stepLo;
   logic       stepHi;
   logic       loWrap;
   logic       hiWrap;
   logic       capEvt;
   logic       setHi;
   logic       setLo;

   // ****************************************
   // Bus front end and rate enables
   // ****************************************
   srt_axil_slave u_bus
   (
      .core_clk (core_clk),
      .nrst     (nrst),
      .awvalid  (awvalid),
      .awready  (awready),
      .awaddr   (awaddr),
      .wvalid   (wvalid),
      .wready   (wready),
      .wdata    (wdata),
      .wstrb    (wstrb),
      .bvalid   (bvalid),
      .bready   (bready),
      .bresp    (bresp),
      .arvalid  (arvalid),
      .arready  (arready),
      .araddr   (araddr),
      .rvalid   (rvalid),
      .rready   (rready),
      .rdata    (rdata),
      .rresp    (rresp),
      .wrEn     (wrEn),
      .wrReq    (wrReq),
      .wrOk     (wrOk),
      .rdEn     (rdEn),
      .rdData   (rdData),
      .rdOk     (rdOk)
   );

   srt_tick_gen u_tick
   (
      .core_clk   (core_clk),
      .nrst       (nrst),
      .extOsc     (extOsc),
      .tickDiv12  (tickDiv12),
      .tickExt8   (tickExt8),
      .captureEvt (captureEvt)
   );

   // ****************************************
   // Address decode
   // ****************************************
   always_comb
   begin
      unique case (wrReq.addr)
         `SRT_OFS_CTRL, `SRT_OFS_CLKCTL, `SRT_OFS_IE, `SRT_OFS_CNT_LO,
         `SRT_OFS_CNT_HI, `SRT_OFS_RLD_LO, `SRT_OFS_RLD_HI,
         `SRT_OFS_IRQ_ST, `SRT_OFS_IRQ_MASK:
            wrOk = 1'b1;
         default:
            wrOk = 1'b0;
      endcase
   end

   assign wrSel   = wrEn & wrReq.strb[0];
   assign ctrlWr  = wrSel & (wrReq.addr == `SRT_OFS_CTRL);
   assign clkWr   = wrSel & (wrReq.addr == `SRT_OFS_CLKCTL);
   assign ieWr    = wrSel & (wrReq.addr == `SRT_OFS_IE);
   assign cntLoWr = wrSel & (wrReq.addr == `SRT_OFS_CNT_LO);
   assign cntHiWr = wrSel & (wrReq.addr == `SRT_OFS_CNT_HI);
   assign rldLoWr = wrSel & (wrReq.addr == `SRT_OFS_RLD_LO);
   assign rldHiWr = wrSel & (wrReq.addr == `SRT_OFS_RLD_HI);
   assign maskWr  = wrSel & (wrReq.addr == `SRT_OFS_IRQ_MASK);
   assign stRd    = rdEn & (araddr == `SRT_OFS_IRQ_ST);

   always_comb
   begin
      rdOk   = 1'b1;
      rdData = 32'h0;
      unique case (araddr)
         `SRT_OFS_CTRL:     rdData[7:0] = ctrl_reg;
         `SRT_OFS_CLKCTL:   rdData[7:0] = clkCtl_reg;
         `SRT_OFS_IE:       rdData[7:0] = intEn_reg;
         `SRT_OFS_CNT_LO:   rdData[7:0] = cntLo_reg;
         `SRT_OFS_CNT_HI:   rdData[7:0] = cntHi_reg;
         `SRT_OFS_RLD_LO:   rdData[7:0] = rldLo_reg;
         `SRT_OFS_RLD_HI:   rdData[7:0] = rldHi_reg;
         `SRT_OFS_IRQ_ST:   rdData[1:0] = irqSt_reg;
         `SRT_OFS_IRQ_MASK: rdData[1:0] = irqMask_reg;
         default:           rdOk        = 1'b0;
      endcase
   end

   // ****************************************
   // Count enables and overflow events
   // ****************************************
   always_comb
   begin
      extLo  = ctrl_reg.extSel & ~ctrl_reg.capEn;
      tickLo = clkCtl_reg[`SRT_BIT_LO_SEL] | (extLo ? tickExt8 : tickDiv12);
      tickHi = clkCtl_reg[`SRT_BIT_HI_SEL] | (ctrl_reg.extSel ? tickExt8 : tickDiv12);
      step16 = ~ctrl_reg.split & ctrl_reg.run & tickLo;
      wrap16 = step16 & ({cntHi_reg, cntLo_reg} == 16'hffff);
      stepLo = ctrl_reg.split & tickLo;
      stepHi = ctrl_reg.split & ctrl_reg.run & tickHi;
      loWrap = (step16 | stepLo) & (cntLo_reg == 8'hff);
      hiWrap = wrap16 | (stepHi & (cntHi_reg == 8'hff));
      capEvt = ctrl_reg.capEn & captureEvt;
      setHi  = hiWrap | capEvt;
      setLo  = loWrap;
   end

   always_comb
   begin
      cntLo_next = cntLo_reg;
      cntHi_next = cntHi_reg;
      if (wrap16)
      begin
         cntLo_next = rldLo_reg;
         cntHi_next = rldHi_reg;
      end
      else if (step16)
      begin
         {cntHi_next, cntLo_next} = {cntHi_reg, cntLo_reg} + 16'h1;
      end
      if (stepLo)
      begin
         cntLo_next = (cntLo_reg == 8'hff) ? rldLo_reg : cntLo_reg + 8'h1;
      end
      if (stepHi)
      begin
         cntHi_next = (cntHi_reg == 8'hff) ? rldHi_reg : cntHi_reg + 8'h1;
      end
   end

   // ****************************************
   // Counter bytes
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cntLo_reg <= 8'h00;
         cntHi_reg <= 8'h00;
      end
      else
      begin
         cntLo_reg <= cntLoWr ? wrReq.data[7:0] : cntLo_next;
         cntHi_reg <= cntHiWr ? wrReq.data[7:0] : cntHi_next;
      end
   end

   // ****************************************
   // Reload bytes
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rldLo_reg <= 8'h00;
         rldHi_reg <= 8'h00;
      end
      else if (capEvt)
      begin
         rldLo_reg <= cntLo_reg;
         rldHi_reg <= cntHi_reg;
      end
      else
      begin
         if (rldLoWr)
         begin
            rldLo_reg <= wrReq.data[7:0];
         end
         if (rldHiWr)
         begin
            rldHi_reg <= wrReq.data[7:0];
         end
      end
   end

   // ****************************************
   // Control, clock select and enable registers
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_reg <= srt_ctrl_s'(`SRT_CTRL_RST);
      end
      else
      begin
         if (ctrlWr)
         begin
            ctrl_reg <= srt_ctrl_s'(wrReq.data[7:0] & `SRT_CTRL_WMASK);
         end
         if (setHi)
         begin
            ctrl_reg.hiFlag <= 1'b1;
         end
         if (setLo)
         begin
            ctrl_reg.loFlag <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         clkCtl_reg <= `SRT_CLKCTL_RST;
         intEn_reg  <= `SRT_IE_RST;
      end
      else
      begin
         if (clkWr)
         begin
            clkCtl_reg <= wrReq.data[7:0];
         end
         if (ieWr)
         begin
            intEn_reg <= wrReq.data[7:0];
         end
      end
   end

   // ****************************************
   // Interrupt status, mask and request
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irqSt_reg <= 2'h0;
      end
      else
      begin
         if (stRd)
         begin
            irqSt_reg <= 2'h0;
         end
         if (setHi)
         begin
            irqSt_reg[`SRT_ST_HI] <= 1'b1;
         end
         if (setLo)
         begin
            irqSt_reg[`SRT_ST_LO] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irqMask_reg <= `SRT_MASK_RST;
      end
      else if (maskWr)
      begin
         irqMask_reg <= wrReq.data[1:0];
      end
   end

   always_comb
   begin
      irq_next = intEn_reg[`SRT_BIT_TMR_IE] &
                 ((irqSt_reg[`SRT_ST_HI] & irqMask_reg[`SRT_ST_HI]) |
                  (irqSt_reg[`SRT_ST_LO] & irqMask_reg[`SRT_ST_LO] &
                   ctrl_reg.loIrqEn));
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= irq_next;
      end
   end
endmodule

/* File: bench/srt_timer_chk.sv */
// Concurrent checks on the bus and interrupt ports of the reload timer.
`timescale 1ns/1ns
module srt_timer_chk
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ****************************************
   // Bus and interrupt properties
   // ****************************************
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read response dropped early");
   wr_lat_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   rd_lat_a: assert property (arvalid && arready |=> rvalid)
      else $error("read response late");
   aw_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken during response");
   rd_err_a: assert property (arvalid && arready && araddr > 8'h20 |=> rresp == 2'h2)
      else $error("unmapped read not refused");
   rd_ok_a: assert property (arvalid && arready && araddr <= 8'h20 && araddr[1:0] == 2'h0
      |=> rresp == 2'h0)
      else $error("mapped read refused");
   rd_width_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   irq_clear_a: assert property ($fell(irq) |-> $past(rvalid) || $past(bvalid)
      || $past(rvalid, 2) || $past(bvalid, 2))
      else $error("interrupt dropped without software access");
   irq_c: cover property ($rose(irq));
   err_c: cover property (rvalid && rresp == 2'h2);
   wr_c: cover property (bvalid && bready);
endmodule
bind srt_timer srt_timer_chk srt_timer_chk_i
(
   .core_clk(core_clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq)
);

/* File: bench/test_srt_timer.sv */
// Self-checking testbench of the reload timer through its AXI4-Lite port.
`timescale 1ns/1ns
`include "srt_cfg.svh"
module test_srt_timer;
   logic        core_clk, nrst, extOsc, irq;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr, v1;
   logic [31:0] wdata, rdata, rdV;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   int          errors, check_count;

   srt_timer srt_timer_i
   (
      .core_clk(core_clk), .nrst(nrst), .extOsc(extOsc), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq)
   );

   // ****************************************
   // Clock, oscillator and run control
   // ****************************************
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial
   begin
      extOsc = 1'b0;
      forever
      begin
         repeat (2) @(posedge core_clk);
         extOsc <= ~extOsc;
      end
   end

   task automatic finish_test();
      $display("errors=%0d check_count=%0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 200)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
         finish_test();
      end
   endtask

   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int   n;
      logic awP;
      logic wP;
      n = 0;
      awP = 1'b1;
      wP = 1'b1;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while ((awP || wP) && n < 200)
      begin
         @(posedge core_clk);
         if (awready) awP = 1'b0;
         if (wready) wP = 1'b0;
         awvalid <= awP;
         wvalid <= wP;
         n++;
      end
      tmo(n);
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (!bvalid && n < 200);
      tmo(n);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (!arready && n < 200);
      tmo(n);
      arvalid <= 1'b0;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (!rvalid && n < 200);
      tmo(n);
      rdV = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      int n;
      errors = 0;
      check_count = 0;
      nrst = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      waitc(8);
      nrst <= 1'b1;
      waitc(1);
      rd(`SRT_OFS_CTRL); chk(rdV, 32'h0);
      rd(`SRT_OFS_IRQ_MASK); chk(rdV, 32'h3);
      rd(8'h40); chk(rsp, 2'h2);
      wr(8'h40, 8'h00); chk(rsp, 2'h2);
      wr(`SRT_OFS_CTRL, 8'h02); rd(`SRT_OFS_CTRL); chk(rdV, 32'h0);
      wr(`SRT_OFS_CLKCTL, 8'h10);
      wr(`SRT_OFS_RLD_LO, 8'hf0);
      wr(`SRT_OFS_RLD_HI, 8'hff);
      wr(`SRT_OFS_CNT_HI, 8'hff);
      wr(`SRT_OFS_CNT_LO, 8'hfc);
      waitc(20);
      rd(`SRT_OFS_CNT_LO); chk(rdV, 32'hfc);
      wr(`SRT_OFS_IE, 8'h20);
      wr(`SRT_OFS_CTRL, 8'h04);
      n = 0;
      while (!irq && n < 200)
      begin
         waitc(1);
         n++;
      end
      tmo(n);
      rd(`SRT_OFS_CTRL); chk(rdV[7], 1'b1);
      rd(`SRT_OFS_CNT_HI); chk(rdV, 32'hff);
      wr(`SRT_OFS_CTRL, 8'h00); rd(`SRT_OFS_CTRL); chk(rdV, 32'h0);
      rd(`SRT_OFS_IRQ_ST); chk(rdV[0], 1'b1);
      waitc(3); chk(irq, 1'b0);
      wr(`SRT_OFS_IRQ_MASK, 8'h02);
      wr(`SRT_OFS_CNT_HI, 8'h00);
      wr(`SRT_OFS_CNT_LO, 8'hf0);
      wr(`SRT_OFS_CTRL, 8'h04);
      waitc(40); chk(irq, 1'b0);
      rd(`SRT_OFS_CTRL); chk(rdV[7:6], 2'b01);
      wr(`SRT_OFS_CTRL, 8'h24);
      waitc(3); chk(irq, 1'b1);
      wr(`SRT_OFS_CTRL, 8'h00);
      rd(`SRT_OFS_IRQ_ST);
      rd(`SRT_OFS_CNT_HI); chk(rdV, 32'h01);
      wr(`SRT_OFS_IRQ_MASK, 8'h03);
      wr(`SRT_OFS_CLKCTL, 8'h30);
      wr(`SRT_OFS_RLD_LO, 8'hf0);
      wr(`SRT_OFS_CNT_LO, 8'hfe);
      wr(`SRT_OFS_CNT_HI, 8'h40);
      wr(`SRT_OFS_CTRL, 8'h08);
      waitc(30);
      rd(`SRT_OFS_CTRL); chk(rdV[7:6], 2'b01);
      rd(`SRT_OFS_CNT_HI); chk(rdV, 32'h40);
      rd(`SRT_OFS_CNT_LO); chk(rdV[7:4], 4'hf);
      wr(`SRT_OFS_RLD_HI, 8'h80);
      wr(`SRT_OFS_CNT_HI, 8'hfe);
      wr(`SRT_OFS_CTRL, 8'h0c);
      waitc(20);
      rd(`SRT_OFS_CNT_HI); chk(rdV[7:5], 3'b100);
      rd(`SRT_OFS_CTRL); chk(rdV[7], 1'b1);
      chk(irq, 1'b1);
      wr(`SRT_OFS_CTRL, 8'h00);
      rd(`SRT_OFS_IRQ_ST);
      wr(`SRT_OFS_IE, 8'h00);
      wr(`SRT_OFS_CLKCTL, 8'h00);
      wr(`SRT_OFS_CTRL, 8'h08);
      wr(`SRT_OFS_CNT_LO, 8'h00);
      waitc(120);
      rd(`SRT_OFS_CNT_LO); chk(rdV >= 9 && rdV <= 11, 1'b1);
      wr(`SRT_OFS_CTRL, 8'h09);
      wr(`SRT_OFS_CNT_LO, 8'h00);
      waitc(320);
      rd(`SRT_OFS_CNT_LO); chk(rdV >= 9 && rdV <= 11, 1'b1);
      wr(`SRT_OFS_CTRL, 8'h00);
      wr(`SRT_OFS_CLKCTL, 8'h10);
      wr(`SRT_OFS_CTRL, 8'h14);
      waitc(70);
      rd(`SRT_OFS_CTRL); chk(rdV[7], 1'b1);
      rd(`SRT_OFS_RLD_LO); v1 = rdV[7:0];
      waitc(64);
      rd(`SRT_OFS_RLD_LO); chk(rdV[4:0], v1[4:0]);
      chk(rdV[7:0] != v1, 1'b1);
      finish_test();
   end
endmodule
